// ### rtl/sci_pkg.sv
// Shared constants and types for the serial interface core.
// Assumes a 32-bit APB slave and one 200 MHz clock.
package sci_pkg;
  // Register byte offsets
  localparam logic [7:0] BAUD_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0c;
  // Baud register fields
  localparam int RATE_LSB = 0;
  localparam int PRE_LSB  = 4;
  localparam logic [2:0] PRE_RST = 3'h0;
  // Control register bits
  localparam int CTRL_TE   = 0;
  localparam int CTRL_TIE  = 1;
  localparam int CTRL_TX_DONE_IRQ_EN = 2;
  localparam int CTRL_RE   = 3;
  localparam int CTRL_RIE  = 4;
  localparam int CTRL_ILIE = 5;
  localparam int CTRL_RWU  = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // Prescaler divisors by select code
  localparam logic [5:0] PRE_DIV_1  = 6'h01;
  localparam logic [5:0] PRE_DIV_3  = 6'h03;
  localparam logic [5:0] PRE_DIV_4  = 6'h04;
  localparam logic [5:0] PRE_DIV_13 = 6'h0d;
  localparam logic [5:0] PRE_DIV_39 = 6'h27;
  // Character timing in sample ticks; STOP_IDX and TX_BITS count bits
  localparam logic [3:0] RT_LAST   = 4'hf;
  localparam logic [3:0] SAMPLE_A  = 4'h7;
  localparam logic [3:0] SAMPLE_B  = 4'h8;
  localparam logic [3:0] SAMPLE_C  = 4'h9;
  localparam logic [3:0] STOP_IDX  = 4'h9;
  localparam logic [3:0] TX_BITS   = 4'h9;
  localparam logic [7:0] IDLE_RT   = 8'ha0;
  // Status flags, bit 7 down to bit 1 of the status register
  typedef struct packed {
    logic tx_holding_empty;
    logic tc;
    logic rx_full;
    logic idle;
    logic ovr;
    logic nf;
    logic fe;
  } sci_flags_s;
endpackage : sci_pkg

// ### rtl/sci_baud_gen.sv
// Three-stage baud generator: prescaler, binary rate divider, then bit divider.
// Assumes select inputs come from registers in the same clock domain.
`timescale 1ns/1ps
module sci_baud_gen (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Rate selection
  input  wire logic [2:0] baud_prescale_sel,
  input  wire logic [2:0] rate_divide_sel,
  // Enables
  output logic            rt_tick,
  output logic            bit_tick
);
  logic [5:0] pre_div;
  logic [5:0] pre_cnt_q;
  logic [6:0] rate_cnt_q;
  logic [6:0] rate_mask;
  logic [3:0] bit_cnt_q;
  logic       pre_tick;
  logic       rt_raw;

  // Codes above 100 are not decoded; they fall back to the slowest divisor
  assign pre_div = (baud_prescale_sel == 3'h0) ? sci_pkg::PRE_DIV_1  :   // [RULE_01]
                   (baud_prescale_sel == 3'h1) ? sci_pkg::PRE_DIV_3  :
                   (baud_prescale_sel == 3'h2) ? sci_pkg::PRE_DIV_4  :
                   (baud_prescale_sel == 3'h3) ? sci_pkg::PRE_DIV_13 :
                                                 sci_pkg::PRE_DIV_39;
  assign pre_tick  = (pre_cnt_q >= pre_div - 6'h01);
  assign rate_mask = 7'((8'h01 << rate_divide_sel) - 8'h01);            // [RULE_02]
  assign rt_raw    = pre_tick && ((rate_cnt_q & rate_mask) == rate_mask);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt_q  <= 6'h00;
      rate_cnt_q <= 7'h00;
      bit_cnt_q  <= 4'h0;
      rt_tick    <= 1'b0;
      bit_tick   <= 1'b0;
    end
    else
    begin
      pre_cnt_q <= pre_tick ? 6'h00 : pre_cnt_q + 6'h01;
      if (pre_tick)
        rate_cnt_q <= rate_cnt_q + 7'h01;
      if (rt_raw)
        bit_cnt_q <= bit_cnt_q + 4'h1;
      rt_tick  <= rt_raw;                                                // [RULE_03]
      bit_tick <= rt_raw && (bit_cnt_q == sci_pkg::RT_LAST);             // [RULE_03]
    end
  end
endmodule : sci_baud_gen

// ### rtl/sci_core.sv
// Asynchronous serial interface core with APB register access.
// Assumes rxd is already synchronous to pclk; pins are muxed outside.
//
// Overview of operation
// RULE_01 - Prescaler divides by 1, 3, 4, 13, 39
// RULE_02 - Rate select divides by power of two
// RULE_03 - Sample clock is 16x; bit clock divides by 16
// RULE_04 - Rate select survives reset, writable any time
// RULE_05 - Software keeps low prescale bits zero if top set
// RULE_06 - Flags set by hardware, cleared by servicing sequence
// RULE_07 - Enabling transmitter sets empty and complete flags
// RULE_08 - Holding empty plus enable requests interrupt
// RULE_09 - Transmit complete plus enable requests interrupt
// RULE_10 - Disable finishes current character, drops queued one
// RULE_11 - Only reset aborts a character mid-frame
// RULE_12 - Idle disable returns pin on bit clock
// RULE_13 - Last character still sets complete and empty
// RULE_14 - Full flag set on transfer to holding register
// RULE_15 - Overrun drops new character, keeps holding register
// RULE_16 - Noise and framing describe held character, no interrupt
// RULE_17 - Line idle after one character time high
// RULE_18 - Idle flag only on active-to-idle transition
// RULE_19 - Five receive flags, three may interrupt
// RULE_20 - Status read then data read clears receive flags
// RULE_21 - Idle flag inhibited while wakeup control set
// RULE_22 - Noise set when bit samples disagree
// RULE_23 - Framing error when stop sample is zero
// RULE_24 - All enabled sources share one interrupt line
`timescale 1ns/1ps
module sci_core (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rxd,
  output logic             txd,
  output logic             tx_pin_en,
  // Interrupt request
  output logic             irq
);
  typedef enum logic {RX_IDLE, RX_RECV} rx_state_e;

  // Register state
  logic [2:0]         baud_prescale_sel_q;
  logic [2:0]         rate_divide_sel_q;
  logic [6:0]         ctrl_q;
  sci_pkg::sci_flags_s flags_q;
  sci_pkg::sci_flags_s flags_d;
  sci_pkg::sci_flags_s armed_q;
  logic [7:0]         rx_holding_reg_q;
  logic [7:0]         tx_holding_reg_q;
  logic               hold_full_q;

  // Baud enables
  logic rt_tick;
  logic bit_tick;

  // Bus decode
  logic        setup, acc, mapped;
  logic        hit_baud, hit_ctrl, hit_stat, hit_data;
  logic        wr_baud, wr_ctrl, wr_data, rd_stat, rd_data;
  logic [31:0] rd_mux;

  // Control aliases
  logic tx_run_switch, tx_empty_irq_en, tx_done_irq_en;
  logic rx_en, rx_irq_en, idle_irq_en, receiver_wakeup;
  logic te_prev_q, te_rise;

  // Transmitter
  logic       tx_busy_q;
  logic [8:0] tx_shift_q;
  logic [3:0] tx_cnt_q;
  logic       tx_done;
  logic       tx_load;

  // Receiver
  rx_state_e  rx_state_q;
  logic [3:0] rt_cnt_q;
  logic [3:0] bit_idx_q;
  logic [1:0] smp_q;
  logic [7:0] rx_shift_q;
  logic       noise_acc_q;
  logic       vote, disagree, eval, char_done, false_start;
  logic [7:0] idle_cnt_q;
  logic       line_busy_q;
  logic       idle_event;
  logic       irq_d;

  sci_baud_gen u_baud (
    .pclk              (pclk),
    .presetn           (presetn),
    .baud_prescale_sel (baud_prescale_sel_q),
    .rate_divide_sel   (rate_divide_sel_q),
    .rt_tick           (rt_tick),
    .bit_tick          (bit_tick)
  );

  // One wait state: data is loaded in the first access cycle
  assign setup    = psel && penable && !pready;
  assign acc      = psel && penable && pready;
  assign hit_baud = (paddr == sci_pkg::BAUD_OFS);
  assign hit_ctrl = (paddr == sci_pkg::CTRL_OFS);
  assign hit_stat = (paddr == sci_pkg::STAT_OFS);
  assign hit_data = (paddr == sci_pkg::DATA_OFS);
  assign mapped   = hit_baud || hit_ctrl || hit_stat || hit_data;
  assign wr_baud  = acc && pwrite && hit_baud;
  assign wr_ctrl  = acc && pwrite && hit_ctrl;
  assign rd_stat  = acc && !pwrite && hit_stat;
  assign rd_data  = acc && !pwrite && hit_data;
  assign wr_data  = acc && pwrite && hit_data;

  assign rd_mux = hit_baud ? {25'h0000000, baud_prescale_sel_q, 1'b0, rate_divide_sel_q} :
                  hit_ctrl ? {25'h0000000, ctrl_q} :
                  hit_stat ? {24'h000000, flags_q, 1'b0} :
                  hit_data ? {24'h000000, rx_holding_reg_q} :
                             32'h00000000;

  assign tx_run_switch   = ctrl_q[sci_pkg::CTRL_TE];
  assign tx_empty_irq_en = ctrl_q[sci_pkg::CTRL_TIE];
  assign tx_done_irq_en  = ctrl_q[sci_pkg::CTRL_TX_DONE_IRQ_EN];
  assign rx_en           = ctrl_q[sci_pkg::CTRL_RE];
  assign rx_irq_en       = ctrl_q[sci_pkg::CTRL_RIE];
  assign idle_irq_en     = ctrl_q[sci_pkg::CTRL_ILIE];
  assign receiver_wakeup = ctrl_q[sci_pkg::CTRL_RWU];
  assign te_rise         = tx_run_switch && !te_prev_q;

  // Transmit sequencing on the bit clock
  assign tx_done = bit_tick && tx_busy_q && (tx_cnt_q == 4'h0);
  assign tx_load = bit_tick && (!tx_busy_q || tx_cnt_q == 4'h0)
                   && tx_run_switch && hold_full_q;

  // Majority of three samples around mid-bit
  assign eval        = rt_tick && rx_state_q == RX_RECV && rt_cnt_q == sci_pkg::SAMPLE_C;
  assign vote        = (smp_q[0] & smp_q[1]) | (smp_q[0] & rxd) | (smp_q[1] & rxd);
  assign disagree    = !((smp_q == 2'b11 && rxd) || (smp_q == 2'b00 && !rxd));     // [RULE_22]
  assign false_start = eval && bit_idx_q == 4'h0 && vote;
  assign char_done   = eval && bit_idx_q == sci_pkg::STOP_IDX;
  assign idle_event  = rt_tick && rxd && line_busy_q
                       && idle_cnt_q == sci_pkg::IDLE_RT - 8'h01;                  // [RULE_17]

  // Flag update: a hardware set always beats the servicing clear
  always_comb
  begin
    flags_d = flags_q;
    if (rd_data)
    begin
      flags_d.rx_full = flags_q.rx_full & ~armed_q.rx_full;                                 // [RULE_20]
      flags_d.idle = flags_q.idle & ~armed_q.idle;                                 // [RULE_20]
      flags_d.ovr  = flags_q.ovr  & ~armed_q.ovr;                                  // [RULE_20]
      flags_d.nf   = flags_q.nf   & ~armed_q.nf;                                   // [RULE_20]
      flags_d.fe   = flags_q.fe   & ~armed_q.fe;                                   // [RULE_20]
    end
    if (wr_data)
    begin
      flags_d.tx_holding_empty = flags_q.tx_holding_empty & ~armed_q.tx_holding_empty;                                 // [RULE_06]
      flags_d.tc   = flags_q.tc   & ~armed_q.tc;                                   // [RULE_06]
    end
    if (te_rise)
    begin
      flags_d.tx_holding_empty = 1'b1;                                                         // [RULE_07]
      flags_d.tc   = 1'b1;                                                         // [RULE_07]
    end
    if (tx_load)
      flags_d.tx_holding_empty = 1'b1;
    if (tx_done && !tx_load)
    begin
      flags_d.tc   = 1'b1;                                                         // [RULE_13]
      flags_d.tx_holding_empty = 1'b1;                                                         // [RULE_13]
    end
    if (char_done)
    begin
      if (flags_d.rx_full)
        flags_d.ovr = 1'b1;                                                        // [RULE_15]
      else
      begin
        flags_d.rx_full = 1'b1;                                                       // [RULE_14]
        flags_d.nf   = noise_acc_q | disagree;                                     // [RULE_16]
        flags_d.fe   = !vote;                                                      // [RULE_23]
      end
    end
    if (idle_event && !receiver_wakeup)
      flags_d.idle = 1'b1;                                                         // [RULE_18]
    if (receiver_wakeup)
      flags_d.idle = 1'b0;                                                         // [RULE_21]
  end

  // Noise and framing never reach the request line
  assign irq_d = (flags_q.tx_holding_empty && tx_empty_irq_en)                                 // [RULE_08]
               | (flags_q.tc && tx_done_irq_en)                                    // [RULE_09]
               | ((flags_q.rx_full || flags_q.ovr) && rx_irq_en)                      // [RULE_19]
               | (flags_q.idle && idle_irq_en);                                    // [RULE_24]

  // Rate select has no reset term so it keeps its value through reset
  always_ff @(posedge pclk)
  begin
    if (wr_baud)
      rate_divide_sel_q <= pwdata[sci_pkg::RATE_LSB +: 3];                         // [RULE_04]
  end

  // Bus side and control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata              <= 32'h00000000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      baud_prescale_sel_q <= sci_pkg::PRE_RST;
      ctrl_q              <= sci_pkg::CTRL_RST;
      te_prev_q           <= 1'b0;
      flags_q             <= '0;
      armed_q             <= '0;
      irq                 <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup)
        prdata <= rd_mux;
      if (wr_baud)
        baud_prescale_sel_q <= pwdata[sci_pkg::PRE_LSB +: 3];                      // [RULE_01]
      if (wr_ctrl)
        ctrl_q <= pwdata[6:0];
      te_prev_q <= tx_run_switch;
      flags_q   <= flags_d;
      if (rd_stat)
        armed_q <= flags_q;                                                        // [RULE_20]
      else if (rd_data || wr_data)
        armed_q <= '0;
      irq <= irq_d;
    end
  end

  // Transmitter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_holding_reg_q <= 8'h00;
      hold_full_q      <= 1'b0;
      tx_busy_q        <= 1'b0;
      tx_shift_q       <= 9'h1ff;
      tx_cnt_q         <= 4'h0;
      txd              <= 1'b1;
      tx_pin_en        <= 1'b0;
    end
    else
    begin
      if (wr_data)
      begin
        tx_holding_reg_q <= pwdata[7:0];
        hold_full_q      <= 1'b1;
      end
      else if (!tx_run_switch)
        hold_full_q <= 1'b0;                                                       // [RULE_10]
      else if (tx_load)
        hold_full_q <= 1'b0;
      // Clearing the enable only stops new loads; a frame always runs out
      if (tx_load)
      begin
        tx_busy_q  <= 1'b1;                                                        // [RULE_11]
        tx_shift_q <= {1'b1, tx_holding_reg_q};
        tx_cnt_q   <= sci_pkg::TX_BITS;
        txd        <= 1'b0;
      end
      else if (bit_tick && tx_busy_q)
      begin
        if (tx_cnt_q == 4'h0)
          tx_busy_q <= 1'b0;                                                       // [RULE_10]
        else
        begin
          txd        <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[8:1]};
          tx_cnt_q   <= tx_cnt_q - 4'h1;
        end
      end
      if (tx_run_switch)
        tx_pin_en <= 1'b1;
      else if (bit_tick && !tx_busy_q)
        tx_pin_en <= 1'b0;                                                         // [RULE_12]
    end
  end

  // Receiver and idle-line detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_q       <= RX_IDLE;
      rt_cnt_q         <= 4'h0;
      bit_idx_q        <= 4'h0;
      smp_q            <= 2'b11;
      rx_shift_q       <= 8'h00;
      noise_acc_q      <= 1'b0;
      rx_holding_reg_q <= 8'h00;
      idle_cnt_q       <= 8'h00;
      line_busy_q      <= 1'b0;
    end
    else
    begin
      if (!rx_en)
        rx_state_q <= RX_IDLE;
      else if (rt_tick)
      begin
        unique case (rx_state_q)
          RX_IDLE:
          begin
            if (!rxd)
            begin
              rx_state_q  <= RX_RECV;
              rt_cnt_q    <= 4'h1;
              bit_idx_q   <= 4'h0;
              noise_acc_q <= 1'b0;
            end
          end
          RX_RECV:
          begin
            rt_cnt_q <= rt_cnt_q + 4'h1;
            if (rt_cnt_q == sci_pkg::SAMPLE_A)
              smp_q[0] <= rxd;
            if (rt_cnt_q == sci_pkg::SAMPLE_B)
              smp_q[1] <= rxd;
            if (eval)
            begin
              noise_acc_q <= noise_acc_q | disagree;                               // [RULE_22]
              bit_idx_q   <= bit_idx_q + 4'h1;
              if (bit_idx_q != 4'h0 && bit_idx_q != sci_pkg::STOP_IDX)
                rx_shift_q <= {vote, rx_shift_q[7:1]};
              if (false_start || char_done)
                rx_state_q <= RX_IDLE;
            end
          end
        endcase
      end
      // Holding register is left alone on overrun
      if (char_done && (!flags_q.rx_full || (rd_data && armed_q.rx_full)))
        rx_holding_reg_q <= rx_shift_q;                                          // [RULE_15]
      if (rt_tick)
      begin
        if (!rxd)
        begin
          idle_cnt_q  <= 8'h00;
          line_busy_q <= 1'b1;
        end
        else if (idle_event)
        begin
          idle_cnt_q  <= 8'h00;
          line_busy_q <= 1'b0;                                                     // [RULE_18]
        end
        else if (line_busy_q)
          idle_cnt_q <= idle_cnt_q + 8'h01;
      end
    end
  end
endmodule : sci_core

// ### bench/sci_core_properties.sv
// Assertion checker for the serial core, bound to the core's ports.
// Assumes the APB master holds each request steady until pready.
`timescale 1ns/1ps
module sci_core_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial line and interrupt
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        tx_pin_en,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the control register, rebuilt from completed writes
  logic [6:0] ctrl_q;
  wire done   = psel && penable && pready;
  wire wr_ctl = done && pwrite && paddr == sci_pkg::CTRL_OFS;
  wire te_on  = !ctrl_q[sci_pkg::CTRL_TE] && pwdata[sci_pkg::CTRL_TE];
  wire en_any = |(ctrl_q & 7'h36);
  wire unmap  = paddr[1:0] != 2'h0 || paddr > 8'h0c;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_q <= 7'h00;
    else if (wr_ctl)
      ctrl_q <= pwdata[6:0];

  a_one_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (done && unmap |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_read_upper_zero: assert property (
    done && !pwrite |-> prdata[31:8] == 24'h0 && !(paddr == sci_pkg::STAT_OFS && prdata[0]))
    else $error("unused read bits not zero");
  a_irq_enabled: assert property (irq |-> en_any || $past(en_any))
    else $error("interrupt without any enable");
  a_empty_irq: assert property (wr_ctl && te_on && pwdata[1] |-> ##[1:4] irq)
    else $error("no interrupt for empty holding register");
  a_done_irq: assert property (wr_ctl && te_on && pwdata[2] |-> ##[1:4] irq)
    else $error("no interrupt for transmit complete");
  a_pin_release: assert property (
    $fell(tx_pin_en) |-> !ctrl_q[sci_pkg::CTRL_TE] && $past(txd))
    else $error("pin released while enabled or mid-frame");

  c_irq: cover property ($rose(irq));
  c_release: cover property ($fell(tx_pin_en));
  c_refused: cover property (done && pslverr);
endmodule : sci_core_properties

bind sci_core sci_core_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_pin_en(tx_pin_en),
  .irq(irq));

// ### bench/remote_station.sv
// Remote serial station: sends 8N1 frames on rxd and decodes frames on txd.
// Assumes a fixed bit period of BIT_CYC clock cycles.
`timescale 1ns/1ps
module remote_station #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input  wire logic pclk,
  // Serial line
  output logic      rxd,
  input  wire logic txd,
  input  wire logic tx_pin_en
);
  logic [7:0] got[$];
  initial rxd = 1'b1;
  // Stop level and a one-cycle glitch in data bit 1 are selectable
  task automatic send(input logic [7:0] b, input logic stop, input logic glitch);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      for (int c = 0; c < BIT_CYC; c++)
      begin
        @(posedge pclk);
        rxd <= (glitch && i == 2 && c == BIT_CYC / 2 + 1) ? !f[i] : f[i];
      end
    end
    @(posedge pclk);
    rxd <= 1'b1;
  endtask : send
  // Mid-bit sampling; frames with a low stop level are dropped
  initial
  begin
    logic [7:0] b;
    forever
    begin
      @(negedge txd);
      if (tx_pin_en)
      begin
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CYC) @(posedge pclk);
          b[i] = txd;
        end
        repeat (BIT_CYC) @(posedge pclk);
        if (txd === 1'b1)
          got.push_back(b);
      end
    end
  end
endmodule : remote_station

// ### bench/testbench.sv
// Self-checking bench for the serial core: APB tasks and a remote station.
// Assumes baud register 0 gives a 16-cycle bit for frame traffic.
`timescale 1ns/1ps
module testbench;
  localparam int BIT = 16;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rxd, txd, tx_pin_en, irq;
  int          miscompares, n_compared, len, g;
  int          pre_div[5] = '{1, 3, 4, 13, 39};

  sci_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_pin_en(tx_pin_en), .irq(irq));
  remote_station #(.BIT_CYC(BIT)) station_u (.pclk(pclk), .rxd(rxd), .txd(txd),
    .tx_pin_en(tx_pin_en));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = !pclk;
  end

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang();
    miscompares++;
    results();
  endtask : hang

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      hang();
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_txd(input logic v);
    len = 0;
    while (txd !== v && len < 5000)
    begin
      @(posedge pclk);
      len++;
    end
    if (len >= 5000)
      hang();
  endtask : wait_txd

  // Start bit of an all-ones character lasts exactly one bit period
  task automatic bit_len(input logic [2:0] pre, input logic [2:0] rate, input int exp);
    apb(1'b1, sci_pkg::BAUD_OFS, {25'h0, pre, 1'b0, rate});
    apb(1'b1, sci_pkg::DATA_OFS, 32'hff);
    wait_txd(1'b0);
    wait_txd(1'b1);
    chk(len, exp);
    repeat (10 * exp) @(posedge pclk);
  endtask : bit_len

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge pclk);
    chk(irq, exp);
  endtask : irqchk

  task automatic gap();
    repeat (12 * BIT) @(posedge pclk);
  endtask : gap

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    n_compared = 0;
    do_reset();
    rdchk(sci_pkg::STAT_OFS, 32'h0);
    rdchk(8'h10, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, sci_pkg::BAUD_OFS, 32'h35);
    do_reset();
    rdchk(sci_pkg::BAUD_OFS, 32'h05);
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h03);
    rdchk(sci_pkg::STAT_OFS, 32'hc0);
    irqchk(1'b1);
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h00);
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h05);
    irqchk(1'b1);
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h01);
    irqchk(1'b0);
    $display("control and flag test done");
    // Code 4 keeps the low select bits clear
    for (int i = 1; i < 5; i++) bit_len(i[2:0], 3'h0, pre_div[i] * 16);
    for (int i = 1; i < 8; i++) bit_len(3'h0, i[2:0], 16 << i);
    $display("baud test done");
    apb(1'b1, sci_pkg::BAUD_OFS, 32'h0);
    rdchk(sci_pkg::STAT_OFS, 32'hc0);
    apb(1'b1, sci_pkg::DATA_OFS, 32'h5a);
    apb(1'b0, sci_pkg::STAT_OFS, 32'h0);
    chk(rd & 32'h40, 32'h0);
    gap();
    chk(station_u.got[$], 32'h5a);
    rdchk(sci_pkg::STAT_OFS, 32'hc0);
    g = station_u.got.size();
    apb(1'b1, sci_pkg::DATA_OFS, 32'h3c);
    wait_txd(1'b0);
    apb(1'b1, sci_pkg::DATA_OFS, 32'hc3);
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h00);
    gap();
    chk(station_u.got.size(), g + 1);
    chk(station_u.got[$], 32'h3c);
    rdchk(sci_pkg::STAT_OFS, 32'hc0);
    chk(tx_pin_en, 1'b0);
    $display("transmit test done");
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h38);
    station_u.send(8'ha5, 1'b1, 1'b0);
    gap();
    chk(irq, 1'b1);
    rdchk(sci_pkg::STAT_OFS, 32'hf0);
    rdchk(sci_pkg::DATA_OFS, 32'ha5);
    rdchk(sci_pkg::STAT_OFS, 32'hc0);
    gap();
    rdchk(sci_pkg::STAT_OFS, 32'hc0);
    station_u.send(8'h11, 1'b1, 1'b0);
    station_u.send(8'h22, 1'b1, 1'b0);
    gap();
    rdchk(sci_pkg::STAT_OFS, 32'hf8);
    rdchk(sci_pkg::DATA_OFS, 32'h11);
    // Receiver on with every receive interrupt masked
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h08);
    station_u.send(8'h81, 1'b0, 1'b0);
    gap();
    irqchk(1'b0);
    rdchk(sci_pkg::STAT_OFS, 32'hf2);
    rdchk(sci_pkg::DATA_OFS, 32'h81);
    station_u.send(8'h42, 1'b1, 1'b1);
    gap();
    rdchk(sci_pkg::STAT_OFS, 32'hf4);
    rdchk(sci_pkg::DATA_OFS, 32'h42);
    apb(1'b1, sci_pkg::CTRL_OFS, 32'h48);
    station_u.send(8'h00, 1'b1, 1'b0);
    gap();
    apb(1'b0, sci_pkg::STAT_OFS, 32'h0);
    chk(rd & 32'h10, 32'h0);
    $display("receive test done");
    results();
  end
endmodule : testbench
